// ### design/io_func_pkg.sv
package io_func_pkg;

    // ==========================================================
    // parameter addresses
    localparam logic [15:0] SEL1_ADDR = 16'h0722;
    localparam logic [15:0] SEL2_ADDR = 16'h0724;
    localparam logic [15:0] SEL3_ADDR = 16'h0726;
    localparam logic [15:0] SEL4_ADDR = 16'h0728;
    localparam logic [15:0] DOUT_ADDR = 16'h0822;
    localparam logic [15:0] STATUS_ADDR = 16'h082A;

    // ==========================================================
    // sizes and reset values
    localparam int NUM_LINES = 4;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic [15:0] DOUT_RESET = 16'h0000;

    // ==========================================================
    // function select codes
    localparam logic [15:0] FN_IN_FREE = 16'h0001;
    localparam logic [15:0] FN_IN_FAULT_RESET = 16'h0002;
    localparam logic [15:0] FN_IN_ENABLE = 16'h0003;
    localparam logic [15:0] FN_IN_HALT = 16'h0004;
    localparam logic [15:0] FN_IN_JOG_POS = 16'h0009;
    localparam logic [15:0] FN_IN_JOG_NEG = 16'h000A;
    localparam logic [15:0] FN_IN_JOG_FAST = 16'h000B;
    localparam logic [15:0] FN_IN_REF = 16'h0014;
    localparam logic [15:0] FN_IN_LIM_POS = 16'h0015;
    localparam logic [15:0] FN_IN_LIM_NEG = 16'h0016;
    localparam logic [15:0] FN_OUT_FREE = 16'h0065;
    localparam logic [15:0] FN_OUT_NO_FAULT = 16'h0066;
    localparam logic [15:0] FN_OUT_ACTIVE = 16'h0067;

    // ==========================================================
    // code check per line, line index counts from 0
    function automatic logic code_valid(logic [1:0] line,
                                        logic [15:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            FN_IN_FREE, FN_IN_FAULT_RESET, FN_IN_ENABLE, FN_IN_HALT,
            FN_IN_JOG_POS, FN_IN_JOG_NEG, FN_IN_JOG_FAST, FN_IN_REF,
            FN_OUT_FREE, FN_OUT_NO_FAULT, FN_OUT_ACTIVE: ok = 1'b1;
            FN_IN_LIM_POS: ok = (line == 2'h0);
            FN_IN_LIM_NEG: ok = (line == 2'h1);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // select address to line index, valid flag in bit 2
    function automatic logic [2:0] sel_index(logic [15:0] addr);
        logic [2:0] r;
        r = 3'h0;
        case (addr)
            SEL1_ADDR: r = 3'h4;
            SEL2_ADDR: r = 3'h5;
            SEL3_ADDR: r = 3'h6;
            SEL4_ADDR: r = 3'h7;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // output function codes
    function automatic logic is_output(logic [15:0] code);
        return (code == FN_OUT_FREE) || (code == FN_OUT_NO_FAULT) ||
               (code == FN_OUT_ACTIVE);
    endfunction

endpackage

// ### design/io_func_if.sv
`timescale 1ns/10ps
interface io_func_if;
    logic [15:0] sel [4];
    logic [3:0] lvl;
    logic [3:0] dout;
    logic fault_present;
    logic op_enabled;
    logic local_mode;
    logic [3:0] out_lvl;
    logic [3:0] out_en;
    logic fault_reset;
    logic power_enable;
    logic halt;
    logic jog_pos;
    logic jog_neg;
    logic jog_fast;
    logic ref_sw;
    logic lim_pos;
    logic lim_neg;

    modport owner (
        output sel, lvl, dout, fault_present, op_enabled, local_mode,
        input out_lvl, out_en, fault_reset, power_enable, halt,
        input jog_pos, jog_neg, jog_fast, ref_sw, lim_pos, lim_neg
    );
    modport decoder (
        input sel, lvl, dout, fault_present, op_enabled, local_mode,
        output out_lvl, out_en, fault_reset, power_enable, halt,
        output jog_pos, jog_neg, jog_fast, ref_sw, lim_pos, lim_neg
    );
endinterface

// ### design/io_func_decode.sv
`timescale 1ns/10ps
module io_func_decode (
    io_func_if.decoder fi
);

    // ==========================================================
    // output side of each line
    always_comb begin
        for (int i = 0; i < io_func_pkg::NUM_LINES; i++) begin
            fi.out_en[i] = io_func_pkg::is_output(fi.sel[i]);
            case (fi.sel[i])
                io_func_pkg::FN_OUT_FREE: fi.out_lvl[i] = fi.dout[i];
                io_func_pkg::FN_OUT_NO_FAULT: begin
                    fi.out_lvl[i] = !fi.fault_present;
                end
                io_func_pkg::FN_OUT_ACTIVE: begin
                    fi.out_lvl[i] = fi.op_enabled;
                end
                default: fi.out_lvl[i] = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // input functions, or of every line holding the code
    function automatic logic any_in(logic [15:0] code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < io_func_pkg::NUM_LINES; i++) begin
            r = r | ((fi.sel[i] == code) & fi.lvl[i]);
        end
        return r;
    endfunction

    always_comb begin
        // free input: no internal effect
        fi.fault_reset = fi.local_mode &
                         any_in(io_func_pkg::FN_IN_FAULT_RESET);
        fi.power_enable = fi.local_mode &
                          any_in(io_func_pkg::FN_IN_ENABLE);
        fi.halt = any_in(io_func_pkg::FN_IN_HALT);
        fi.jog_pos = any_in(io_func_pkg::FN_IN_JOG_POS);
        fi.jog_neg = any_in(io_func_pkg::FN_IN_JOG_NEG);
        fi.jog_fast = any_in(io_func_pkg::FN_IN_JOG_FAST);
        fi.ref_sw = any_in(io_func_pkg::FN_IN_REF);
        // limits only ever sit on their own line
        fi.lim_pos = (fi.sel[0] == io_func_pkg::FN_IN_LIM_POS) & fi.lvl[0];
        fi.lim_neg = (fi.sel[1] == io_func_pkg::FN_IN_LIM_NEG) & fi.lvl[1];
    end

endmodule

// ### design/io_line_function_assign.sv
// Summary of operation
// - free-use output line is driven from its direct_output_set bit.
// - no-fault output line shows whether no fault is present.
// - active output line shows the operation-enabled state.
// - direct_output_set bits reach only lines set to free output.
// - direct_output_set: line 1 bit 0 upward, 16 bits, RW, reset 0.
// - all four lines take the eight common input functions.
// - positive limit switch function only on io_line_1.
// - negative limit switch function only on io_line_2.
// - all four lines take the three output functions.
// - input codes 1,2,3,4,9,10,11,20 as listed.
// - code 21 puts positive limit switch on io_line_1.
// - output codes 101,102,103; select is 16-bit RW, reset 0.
// - fault-reset input acts only in local control mode.
// - enable input acts only in local control mode.
// - free input has no effect; level readable in io_line_status.
`timescale 1ns/10ps
module io_line_function_assign (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] par_addr,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_wdata,
    output logic [15:0] par_rdata,
    output logic par_rvalid,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic fault_present,
    input wire logic op_enabled,
    input wire logic local_mode,
    output logic fault_reset_req,
    output logic power_enable_req,
    output logic halt_req,
    output logic jog_pos_req,
    output logic jog_neg_req,
    output logic jog_fast_sel,
    output logic ref_switch,
    output logic limit_pos,
    output logic limit_neg
);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [15:0] sel_q [4];
    logic [15:0] dout_q;
    logic [15:0] status_q;
    logic [2:0] widx;

    io_func_if fi ();

    io_func_decode u_decode (
        .fi(fi)
    );

    // ==========================================================
    // decoder hookup
    always_comb begin
        for (int i = 0; i < io_func_pkg::NUM_LINES; i++) begin
            fi.sel[i] = sel_q[i];
        end
        fi.lvl = io_in;
        fi.dout = dout_q[3:0];
        fi.fault_present = fault_present;
        fi.op_enabled = op_enabled;
        fi.local_mode = local_mode;
    end

    // ==========================================================
    // function select registers
    assign widx = io_func_pkg::sel_index(par_addr);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < io_func_pkg::NUM_LINES; i++) begin
                sel_q[i] <= io_func_pkg::SEL_RESET;
            end
        end else if (par_wr && widx[2] &&
                     io_func_pkg::code_valid(widx[1:0], par_wdata)) begin
            // codes per line
            sel_q[widx[1:0]] <= par_wdata;
        end
    end

    // ==========================================================
    // direct output register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dout_q <= io_func_pkg::DOUT_RESET;
        end else if (par_wr && par_addr == io_func_pkg::DOUT_ADDR) begin
            dout_q <= par_wdata;
        end
    end

    // ==========================================================
    // pin drive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end else begin
            io_out <= fi.out_lvl;
            io_oe <= fi.out_en;
        end
    end

    // ==========================================================
    // line status, driven level for outputs, pin level for inputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_q <= 16'h0000;
        end else begin
            status_q <= {12'h000, (io_oe & io_out) | (~io_oe & io_in)};
        end
    end

    // ==========================================================
    // internal function requests
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_reset_req <= 1'b0;
            power_enable_req <= 1'b0;
            halt_req <= 1'b0;
            jog_pos_req <= 1'b0;
            jog_neg_req <= 1'b0;
            jog_fast_sel <= 1'b0;
            ref_switch <= 1'b0;
            limit_pos <= 1'b0;
            limit_neg <= 1'b0;
        end else begin
            fault_reset_req <= fi.fault_reset;
            power_enable_req <= fi.power_enable;
            halt_req <= fi.halt;
            jog_pos_req <= fi.jog_pos;
            jog_neg_req <= fi.jog_neg;
            jog_fast_sel <= fi.jog_fast;
            ref_switch <= fi.ref_sw;
            limit_pos <= fi.lim_pos;
            limit_neg <= fi.lim_neg;
        end
    end

    // ==========================================================
    // parameter read port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            par_rdata <= 16'h0000;
            par_rvalid <= 1'b0;
        end else begin
            par_rvalid <= par_rd;
            if (par_rd) begin
                if (widx[2]) begin
                    par_rdata <= sel_q[widx[1:0]];
                end else if (par_addr == io_func_pkg::DOUT_ADDR) begin
                    par_rdata <= dout_q;
                end else if (par_addr == io_func_pkg::STATUS_ADDR) begin
                    par_rdata <= status_q;
                end else begin
                    par_rdata <= 16'h0000;
                end
            end
        end
    end

    // ==========================================================
    // checks
    chk_free_out_drive: assert property (
        sel_q[0] == io_func_pkg::FN_OUT_FREE |=>
            io_oe[0] && io_out[0] == $past(dout_q[0]))
        else $error("free output line 1 not following direct bit");

    chk_nofault_out: assert property (
        sel_q[0] == io_func_pkg::FN_OUT_NO_FAULT |=>
            io_out[0] == !$past(fault_present))
        else $error("no-fault output wrong");

    chk_active_out: assert property (
        sel_q[1] == io_func_pkg::FN_OUT_ACTIVE |=>
            io_out[1] == $past(op_enabled))
        else $error("active output wrong");

    chk_input_no_drive: assert property (
        !io_func_pkg::is_output(sel_q[3]) |=> !io_oe[3] && !io_out[3])
        else $error("input line is driven");

    chk_dout_write: assert property (
        par_wr && par_addr == io_func_pkg::DOUT_ADDR |=>
            dout_q == $past(par_wdata))
        else $error("direct output write lost");

    chk_halt_input: assert property (
        sel_q[3] == io_func_pkg::FN_IN_HALT && io_in[3] |=> halt_req)
        else $error("halt input not seen");

    chk_limpos_line: assert property (
        par_wr && par_addr == io_func_pkg::SEL2_ADDR &&
        par_wdata == io_func_pkg::FN_IN_LIM_POS |=>
            sel_q[1] == $past(sel_q[1]))
        else $error("positive limit accepted off line 1");

    chk_limneg_line: assert property (
        par_wr && par_addr == io_func_pkg::SEL1_ADDR &&
        par_wdata == io_func_pkg::FN_IN_LIM_NEG |=>
            sel_q[0] == $past(sel_q[0]))
        else $error("negative limit accepted off line 2");

    chk_limpos_take: assert property (
        par_wr && par_addr == io_func_pkg::SEL1_ADDR &&
        par_wdata == io_func_pkg::FN_IN_LIM_POS |=>
            sel_q[0] == io_func_pkg::FN_IN_LIM_POS ##1
            limit_pos == $past(io_in[0]))
        else $error("positive limit code not applied");

    chk_fault_reset_local: assert property (
        !local_mode |=> !fault_reset_req)
        else $error("fault reset outside local mode");

    chk_enable_local: assert property (
        !local_mode |=> !power_enable_req)
        else $error("enable outside local mode");

    chk_status_input: assert property (
        !io_oe[0] |=> status_q[0] == $past(io_in[0]))
        else $error("status does not show input level");

    chk_bad_code_kept: assert property (
        par_wr && par_addr == io_func_pkg::SEL4_ADDR &&
        !io_func_pkg::code_valid(2'h3, par_wdata) |=>
            $stable(sel_q[3]))
        else $error("undefined code accepted");

    chk_free_out_line3: assert property (
        sel_q[2] == io_func_pkg::FN_OUT_FREE |=>
            io_oe[2] && io_out[2] == $past(dout_q[2]))
        else $error("free output line 3 not following direct bit");

    chk_free_out_line4: assert property (
        sel_q[3] == io_func_pkg::FN_OUT_FREE |=>
            io_oe[3] && io_out[3] == $past(dout_q[3]))
        else $error("free output line 4 not following direct bit");

    chk_nofault_out_oe: assert property (
        sel_q[0] == io_func_pkg::FN_OUT_NO_FAULT |=> io_oe[0])
        else $error("no-fault output line not driven");

    chk_active_out_oe: assert property (
        sel_q[1] == io_func_pkg::FN_OUT_ACTIVE |=> io_oe[1])
        else $error("active output line not driven");

    chk_input_line_one: assert property (
        !io_func_pkg::is_output(sel_q[0]) |=> !io_oe[0] && !io_out[0])
        else $error("input line 1 is driven");

    chk_fault_reset_take: assert property (
        local_mode && sel_q[2] == io_func_pkg::FN_IN_FAULT_RESET &&
        io_in[2] |=> fault_reset_req)
        else $error("fault reset input not seen");

    chk_enable_take: assert property (
        local_mode && sel_q[1] == io_func_pkg::FN_IN_ENABLE &&
        io_in[1] |=> power_enable_req)
        else $error("enable input not seen");

    chk_jog_pos_input: assert property (
        sel_q[0] == io_func_pkg::FN_IN_JOG_POS && io_in[0] |=> jog_pos_req)
        else $error("jog positive input not seen");

    chk_jog_neg_input: assert property (
        sel_q[1] == io_func_pkg::FN_IN_JOG_NEG && io_in[1] |=> jog_neg_req)
        else $error("jog negative input not seen");

    chk_jog_fast_input: assert property (
        sel_q[2] == io_func_pkg::FN_IN_JOG_FAST && io_in[2] |=>
            jog_fast_sel)
        else $error("jog fast input not seen");

    chk_ref_input: assert property (
        sel_q[3] == io_func_pkg::FN_IN_REF && io_in[3] |=> ref_switch)
        else $error("reference switch input not seen");

    chk_free_in_quiet: assert property (
        sel_q[0] == io_func_pkg::FN_IN_FREE &&
        sel_q[1] == io_func_pkg::FN_IN_FREE &&
        sel_q[2] == io_func_pkg::FN_IN_FREE &&
        sel_q[3] == io_func_pkg::FN_IN_FREE |=>
            !fault_reset_req && !power_enable_req && !halt_req &&
            !jog_pos_req && !jog_neg_req && !jog_fast_sel &&
            !ref_switch && !limit_pos && !limit_neg)
        else $error("free input caused an internal request");

    chk_limneg_take: assert property (
        sel_q[1] == io_func_pkg::FN_IN_LIM_NEG |=>
            limit_neg == $past(io_in[1]))
        else $error("negative limit level not passed");

    chk_sel_take: assert property (
        par_wr && par_addr == io_func_pkg::SEL3_ADDR &&
        par_wdata == io_func_pkg::FN_IN_HALT |=>
            sel_q[2] == io_func_pkg::FN_IN_HALT)
        else $error("halt code not stored");

    chk_status_driven: assert property (
        io_oe[1] |=> status_q[1] == $past(io_out[1]))
        else $error("status does not show driven level");

    chk_read_answer: assert property (
        par_rd |=> par_rvalid)
        else $error("read not answered");

    chk_dout_read: assert property (
        par_rd && par_addr == io_func_pkg::DOUT_ADDR |=>
            par_rdata == $past(dout_q))
        else $error("direct output read wrong");

endmodule

// ### test/line_partner.sv
`timescale 1ns/10ps
// ==========================================================
// switches and loads hung on the four lines
module line_partner (
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    input wire logic [3:0] sw,
    output logic [3:0] io_in
);
    // a driven line carries the device level, else the switch level
    assign io_in = (io_oe & io_out) | (~io_oe & sw);
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end

module testbench;
    logic clk_sys, rst, par_wr, par_rd, par_rvalid;
    logic [15:0] par_addr, par_wdata, par_rdata;
    logic [3:0] io_in, io_out, io_oe, sw;
    logic fault_present, op_enabled, local_mode, f;
    logic fault_reset_req, power_enable_req, halt_req, jog_pos_req;
    logic jog_neg_req, jog_fast_sel, ref_switch, limit_pos, limit_neg;
    logic [8:0] req;
    int err_total, num_checks;
    logic [15:0] codes [7] = '{16'h0002, 16'h0003, 16'h0004, 16'h0009,
                               16'h000A, 16'h000B, 16'h0014};

    assign req = {fault_reset_req, power_enable_req, halt_req,
                  jog_pos_req, jog_neg_req, jog_fast_sel, ref_switch,
                  limit_pos, limit_neg};

    io_line_function_assign uut (
        .clk_sys(clk_sys), .rst(rst), .par_addr(par_addr),
        .par_wr(par_wr), .par_rd(par_rd), .par_wdata(par_wdata),
        .par_rdata(par_rdata), .par_rvalid(par_rvalid), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .fault_present(fault_present),
        .op_enabled(op_enabled), .local_mode(local_mode),
        .fault_reset_req(fault_reset_req),
        .power_enable_req(power_enable_req), .halt_req(halt_req),
        .jog_pos_req(jog_pos_req), .jog_neg_req(jog_neg_req),
        .jog_fast_sel(jog_fast_sel), .ref_switch(ref_switch),
        .limit_pos(limit_pos), .limit_neg(limit_neg)
    );

    line_partner loads (
        .io_out(io_out), .io_oe(io_oe), .sw(sw), .io_in(io_in)
    );

    // ==========================================================
    // clock and access tasks
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    function automatic logic [15:0] sel(input int i);
        return io_func_pkg::SEL1_ADDR + 16'(2 * i);
    endfunction

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        step(1);
        par_addr = a;
        par_wdata = d;
        par_wr = 1'b1;
        step(1);
        par_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e,
                          input string nm);
        step(1);
        par_addr = a;
        par_rd = 1'b1;
        step(1);
        par_rd = 1'b0;
        `CHK(nm, 1'b1, par_rvalid)
        `CHK(nm, e, par_rdata)
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // test sequence
    initial begin
        {par_wr, par_rd, fault_present, op_enabled, local_mode} = 5'h00;
        par_addr = 16'h0000;
        par_wdata = 16'h0000;
        sw = 4'h0;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #5;
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd_chk(sel(i), 16'h0000, "select reset");
        end
        rd_chk(io_func_pkg::DOUT_ADDR, 16'h0000, "dout reset");
        `CHK("oe reset", 4'h0, io_oe)
        wr(io_func_pkg::DOUT_ADDR, 16'hA5A5);
        rd_chk(io_func_pkg::DOUT_ADDR, 16'hA5A5, "dout rw");
        step(2);
        `CHK("oe input lines", 4'h0, io_oe)
        for (int i = 0; i < 4; i++) begin
            wr(sel(i), io_func_pkg::FN_OUT_FREE);
        end
        step(2);
        `CHK("oe free out", 4'hF, io_oe)
        `CHK("free out level", 4'h5, io_out)
        wr(io_func_pkg::DOUT_ADDR, 16'h000A);
        step(2);
        `CHK("dout bit map", 4'hA, io_out)
        rd_chk(io_func_pkg::STATUS_ADDR, 16'h000A, "status out");
        wr(sel(0), io_func_pkg::FN_OUT_NO_FAULT);
        wr(sel(1), io_func_pkg::FN_OUT_ACTIVE);
        for (int j = 0; j < 2; j++) begin
            f = j[0];
            fault_present = f;
            op_enabled = ~f;
            step(2);
            `CHK("no fault out", ~f, io_out[0])
            `CHK("active out", ~f, io_out[1])
        end
        wr(io_func_pkg::DOUT_ADDR, 16'h0003);
        step(2);
        `CHK("dout masked", 4'h0, io_out)
        for (int i = 0; i < 4; i++) begin
            wr(sel(i), io_func_pkg::FN_IN_FREE);
        end
        local_mode = 1'b1;
        sw = 4'hF;
        step(2);
        `CHK("free in req", 9'h000, req)
        `CHK("oe free in", 4'h0, io_oe)
        rd_chk(io_func_pkg::STATUS_ADDR, 16'h000F, "status in");
        sw = 4'h0;
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 7; k++) begin
                wr(sel(i), codes[k]);
                sw = 4'h1 << i;
                step(2);
                `CHK("input function", 9'h100 >> k, req)
                if (k < 2) begin
                    local_mode = 1'b0;
                    step(2);
                    `CHK("remote gate", 9'h000, req)
                    local_mode = 1'b1;
                end
                sw = 4'h0;
                step(2);
                `CHK("input released", 9'h000, req)
                wr(sel(i), io_func_pkg::FN_IN_FREE);
            end
        end
        wr(sel(0), io_func_pkg::FN_IN_LIM_POS);
        sw = 4'h1;
        step(2);
        `CHK("limit pos", 9'h002, req)
        wr(sel(1), io_func_pkg::FN_IN_LIM_POS);
        rd_chk(sel(1), io_func_pkg::FN_IN_FREE, "pos on line2");
        wr(sel(0), io_func_pkg::FN_IN_LIM_NEG);
        rd_chk(sel(0), io_func_pkg::FN_IN_LIM_POS, "neg on line1");
        wr(sel(1), io_func_pkg::FN_IN_LIM_NEG);
        sw = 4'h2;
        step(2);
        `CHK("limit neg", 9'h001, req)
        wr(sel(2), 16'h0005);
        rd_chk(sel(2), io_func_pkg::FN_IN_FREE, "bad code");
        wr(sel(3), 16'h0000);
        rd_chk(sel(3), io_func_pkg::FN_IN_FREE, "zero code");
        print_verdict();
    end

    // ==========================================================
    // watchdog, about twelve times the expected run
    initial begin
        #(50 * 4000);
        err_total++;
        print_verdict();
    end
endmodule
